// File: verilog/quad_phase_reset_sequencer.sv
// quad phase clock generator and reset sequencer with an axi4-lite slave
`timescale 1ns/1ps
`default_nettype none

module quad_phase_reset_sequencer #(
  parameter int POWER_UP_TIMER_COUNT = qprs_pkg::POWER_UP_TIMER_TICKS
) (
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        OSC_INPUT_IN,
  input  wire logic        OSC_LEVEL_OK_IN,
  input  wire logic        RC_TICK_IN,
  input  wire logic        POWER_OK_IN,
  input  wire logic        BROWN_OUT_IN,
  input  wire logic        MASTER_CLEAR_N_IN,
  input  wire logic        WATCHDOG_TIMEOUT_IN,
  input  wire logic        WATCHDOG_CLEAR_INSTR_IN,
  input  wire logic        SLEEP_INSTR_IN,
  input  wire logic        INT_WAKE_IN,
  input  wire logic        GLOBAL_INT_DISABLE_IN,
  input  wire logic        PC_LOAD_IN,
  input  wire logic [15:0] PC_TARGET_IN,
  input  wire logic        EXT_EXEC_MODE_IN,
  output logic      [3:0]  PHASE_OUT,
  output logic             DEVICE_RESET_OUT,
  output logic      [15:0] PC_OUT,
  output logic             INSTR_LATCH_OUT,
  output logic             EXECUTE_VALID_OUT,
  output logic             OPERAND_READ_OUT,
  output logic             RESULT_WRITE_OUT,
  output logic             VECTOR_FETCH_OUT,
  output logic             ALE_OUT,
  output logic             OE_N_OUT,
  output logic             WR_N_OUT,
  output logic             BUS_PINS_OE_OUT,
  output logic             QUARTER_CLOCK_OUT,
  output logic             QUARTER_CLOCK_OE_OUT,
  input  wire logic [3:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic      [1:0]  S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [3:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic      [31:0] S_AXI_RDATA_OUT,
  output logic      [1:0]  S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN
);
  import qprs_pkg::*;

  localparam logic [16:0] POWER_UP_TIMER_LOAD = 17'(POWER_UP_TIMER_COUNT);

  seq_regs_type r_q;
  seq_regs_type r_d;
  logic [31:0]  keep_q;   // survives every reset
  logic         osc_rise;
  logic         running;
  logic         q4_end;
  logic         wr_go;
  logic         rd_go;

  // crystal or low-frequency crystal oscillator selected
  function automatic logic is_crystal(input logic [1:0] mode);
    return (mode == MODE_CRYSTAL) || (mode == MODE_LF_XTAL);
  endfunction

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  // the oscillator pin is sampled on the system clock, so it must stay
  // well below half of 100 MHz or periods will be missed
  assign osc_rise = OSC_INPUT_IN && !r_q.osc_prev;
  assign running  = (r_q.state == ST_RUN);
  assign q4_end   = running && osc_rise && (r_q.phase == 2'd3);
  assign wr_go    = r_q.aw_full && r_q.w_full && !r_q.bvalid;
  assign rd_go    = S_AXI_ARVALID_IN && !r_q.rvalid;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d          = r_q;
    r_d.osc_prev = OSC_INPUT_IN;
    r_d.vec_fire = 1'b0;
    if (OSC_LEVEL_OK_IN) begin
      r_d.osc_ok = 1'b1;
    end

    // phase generator and pipeline, only while running
    // four phases in order
    if (running && osc_rise) begin
      r_d.phase = r_q.phase + 2'd1;
    end
    // pc moves at entry to the first phase
    if (q4_end) begin
      r_d.flush = 1'b0;
      // vector fetched after the instruction following sleep
      if (r_q.vec_pend) begin
        r_d.pc       = INT_VECTOR;
        r_d.vec_pend = 1'b0;
        r_d.vec_fire = 1'b1;
        r_d.flush    = 1'b1;
      // a pc load discards the fetched word, costing a second cycle
      end else if (PC_LOAD_IN) begin
        r_d.pc    = PC_TARGET_IN;
        r_d.flush = 1'b1;
      end else begin
        r_d.pc = r_q.pc + 16'd1;
      end
    end

    // software may set power-on and brown-out bits and the interrupt disable
    if (wr_go && r_q.aw_addr == STATUS_ADDR) begin
      r_d.flags[ST_GLINT_BIT] = r_q.w_data[ST_GLINT_BIT];
      r_d.flags[1:0]          = r_q.w_data[1:0];
    end
    if (wr_go && r_q.aw_addr == CTRL_ADDR) begin
      r_d.ctrl = r_q.w_data[2:0];
    end

    // sequencer; hardware events below override a software write
    case (r_q.state)
      ST_POWER_DOWN: begin
        r_d.pc = RESET_VECTOR;
        if (MASTER_CLEAR_N_IN) begin
          // both timers start once master clear is seen high
          r_d.state    = ST_POWER_UP;
          r_d.power_up_timer_cnt = POWER_UP_TIMER_LOAD;
          r_d.ost_cnt  = OST_PERIODS;
          r_d.osc_ok   = OSC_LEVEL_OK_IN;
        end else begin
          r_d.state = ST_WAIT_CLEAR;
        end
      end
      ST_WAIT_CLEAR: begin
        if (MASTER_CLEAR_N_IN) begin
          r_d.state    = ST_POWER_UP;
          r_d.power_up_timer_cnt = POWER_UP_TIMER_LOAD;
          r_d.ost_cnt  = OST_PERIODS;
          r_d.osc_ok   = OSC_LEVEL_OK_IN;
        end
      end
      ST_POWER_UP: begin
        // power-up timer counts internal rc ticks
        if (RC_TICK_IN && r_q.power_up_timer_cnt != 17'd0) begin
          r_d.power_up_timer_cnt = r_q.power_up_timer_cnt - 17'd1;
        end
        // oscillator pulses count only once the level is valid
        if (osc_rise && r_q.osc_ok && r_q.ost_cnt != 11'd0) begin
          r_d.ost_cnt = r_q.ost_cnt - 11'd1;
        end
        // the longer of both timers ends power-up in every mode
        if (r_q.power_up_timer_cnt == 17'd0 && r_q.ost_cnt == 11'd0) begin
          r_d.state = ST_RUN;
        end
      end
      ST_WAKE: begin
        // start-up count after a sleep wake, crystal modes
        if (osc_rise && r_q.osc_ok && r_q.ost_cnt != 11'd0) begin
          r_d.ost_cnt = r_q.ost_cnt - 11'd1;
        end
        if (r_q.ost_cnt == 11'd0) begin
          r_d.state = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (MASTER_CLEAR_N_IN && !(BROWN_OUT_IN && r_q.ctrl[CTRL_BOR_EN])) begin
          // only a master clear taken in sleep in a crystal mode adds the start-up count
          if (r_q.hold_from_sleep && is_crystal(r_q.ctrl[1:0])) begin
            r_d.state   = ST_WAKE;
            r_d.ost_cnt = OST_PERIODS;
            r_d.osc_ok  = OSC_LEVEL_OK_IN;
          end else begin
            r_d.state = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        // watchdog clear sets timeout and powerdown
        if (WATCHDOG_CLEAR_INSTR_IN) begin
          r_d.flags[3:2] = 2'b11;
        end
        if (SLEEP_INSTR_IN) begin
          r_d.state      = ST_SLEEP;
          r_d.flags[3:2] = 2'b10;
        end
        if (WATCHDOG_TIMEOUT_IN) begin
          r_d.flags = FLAGS_WDT;
          r_d.pc    = RESET_VECTOR;
          r_d.phase = 2'd0;
        end
      end
      ST_SLEEP: begin
        // a watchdog event in sleep resumes operation from zero
        if (WATCHDOG_TIMEOUT_IN) begin
          r_d.flags   = FLAGS_WDT_WAKE;
          r_d.pc      = RESET_VECTOR;
          r_d.state   = is_crystal(r_q.ctrl[1:0]) ? ST_WAKE : ST_RUN;
          r_d.ost_cnt = OST_PERIODS;
          r_d.osc_ok  = OSC_LEVEL_OK_IN;
        // interrupt wake continues at the next address
        end else if (INT_WAKE_IN) begin
          r_d.flags    = {1'b1, GLOBAL_INT_DISABLE_IN, LOW_INT_WAKE};
          r_d.pc       = r_q.pc + 16'd1;
          r_d.vec_pend = !GLOBAL_INT_DISABLE_IN;
          r_d.state    = is_crystal(r_q.ctrl[1:0]) ? ST_WAKE : ST_RUN;
          r_d.ost_cnt  = OST_PERIODS;
          r_d.osc_ok   = OSC_LEVEL_OK_IN;
        end
      end
      default: begin
        r_d.state = ST_POWER_DOWN;
      end
    endcase

    // master clear and brown-out win over run and sleep events
    // status bits per event
    if (r_q.state == ST_RUN || r_q.state == ST_SLEEP) begin
      // brown-out only acts when detection is enabled
      if (BROWN_OUT_IN && r_q.ctrl[CTRL_BOR_EN]) begin
        r_d.flags           = FLAGS_BOR;
        r_d.state           = ST_HOLD;
        r_d.hold_from_sleep = 1'b0;
      end else if (!MASTER_CLEAR_N_IN) begin
        // cause flags by the state the clear arrived in
        r_d.flags           = running ? FLAGS_MASTER_CLEAR_N : FLAGS_MASTER_CLEAR_N_SLP;
        r_d.state           = ST_HOLD;
        r_d.hold_from_sleep = !running;
      end
    end

    // every reset path parks pc at the reset vector
    if (r_d.state == ST_HOLD || r_d.state == ST_POWER_UP) begin
      r_d.pc       = RESET_VECTOR;
      r_d.vec_pend = 1'b0;
      r_d.flush    = 1'b0;
    end
    // phase generator rests in the first phase outside run
    if (r_d.state != ST_RUN) begin
      r_d.phase = 2'd0;
    end

    // low supply forces the power-on state over everything
    if (!POWER_OK_IN) begin
      r_d.state    = ST_POWER_DOWN;
      r_d.flags    = FLAGS_POR;
      r_d.pc       = RESET_VECTOR;
      r_d.phase    = 2'd0;
      r_d.vec_pend = 1'b0;
      r_d.flush    = 1'b0;
    end

    // axi4-lite write: address and data taken in either order
    if (S_AXI_AWVALID_IN && !r_q.aw_full) begin
      r_d.aw_full = 1'b1;
      r_d.aw_addr = {S_AXI_AWADDR_IN[3:2], 2'b00};
    end
    if (S_AXI_WVALID_IN && !r_q.w_full) begin
      r_d.w_full = 1'b1;
      r_d.w_data = S_AXI_WDATA_IN;
      r_d.w_strb = S_AXI_WSTRB_IN;
    end
    if (wr_go) begin
      r_d.aw_full = 1'b0;
      r_d.w_full  = 1'b0;
      r_d.bvalid  = 1'b1;
      r_d.bresp   = (r_q.aw_addr == SEQ_ADDR) ? AXI_DECERR : AXI_OKAY;
    end
    if (r_q.bvalid && S_AXI_BREADY_IN) begin
      r_d.bvalid = 1'b0;
    end

    // axi4-lite read: one cycle from address to data
    if (rd_go) begin
      r_d.rvalid = 1'b1;
      r_d.rresp  = AXI_OKAY;
      case ({S_AXI_ARADDR_IN[3:2], 2'b00})
        CTRL_ADDR:   r_d.rdata = {29'h0000_0000, r_q.ctrl};
        STATUS_ADDR: r_d.rdata = {26'h000_0000, r_q.flags};
        SEQ_ADDR:    r_d.rdata = {8'h00, 3'(r_q.state), 3'h0, r_q.phase, r_q.pc};
        KEEP_ADDR:   r_d.rdata = keep_q;
        default: begin
          r_d.rdata = 32'h0000_0000;
          r_d.rresp = AXI_DECERR;
        end
      endcase
    end
    if (r_q.rvalid && S_AXI_RREADY_IN) begin
      r_d.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      r_q       <= '0;
      r_q.state <= ST_POWER_DOWN;
      r_q.flags <= FLAGS_POR;
      r_q.ctrl  <= CTRL_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // scratch word has no reset so it keeps contents across resets
  always_ff @(posedge CLK_IN) begin
    if (wr_go && r_q.aw_addr == KEEP_ADDR) begin
      for (int b = 0; b < 4; b++) begin
        if (r_q.w_strb[b]) begin
          keep_q[8*b +: 8] <= r_q.w_data[8*b +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // reset held through every state but run and sleep
  assign DEVICE_RESET_OUT  = !(running || r_q.state == ST_SLEEP);
  assign PHASE_OUT         = 4'b0001 << r_q.phase;
  assign PC_OUT            = r_q.pc;
  assign INSTR_LATCH_OUT   = running && (r_q.phase == 2'd3);
  assign EXECUTE_VALID_OUT = running && !r_q.flush;
  // operand read in the second phase, write-back in the fourth
  assign OPERAND_READ_OUT  = EXECUTE_VALID_OUT && (r_q.phase == 2'd1);
  assign RESULT_WRITE_OUT  = EXECUTE_VALID_OUT && (r_q.phase == 2'd3);
  assign VECTOR_FETCH_OUT  = r_q.vec_fire;
  // bus strobes always parked; pin drivers enabled only in reset with external execution
  assign BUS_PINS_OE_OUT   = DEVICE_RESET_OUT && EXT_EXEC_MODE_IN;
  assign ALE_OUT           = 1'b0;
  assign OE_N_OUT          = 1'b1;
  assign WR_N_OUT          = 1'b1;
  // quarter clock, low in the first two phases, high in the last two
  assign QUARTER_CLOCK_OUT    = r_q.phase[1];
  assign QUARTER_CLOCK_OE_OUT = !is_crystal(r_q.ctrl[1:0]);

  assign S_AXI_AWREADY_OUT = !r_q.aw_full;
  assign S_AXI_WREADY_OUT  = !r_q.w_full;
  assign S_AXI_BVALID_OUT  = r_q.bvalid;
  assign S_AXI_BRESP_OUT   = r_q.bresp;
  assign S_AXI_ARREADY_OUT = !r_q.rvalid;
  assign S_AXI_RVALID_OUT  = r_q.rvalid;
  assign S_AXI_RDATA_OUT   = r_q.rdata;
  assign S_AXI_RRESP_OUT   = r_q.rresp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  phase_order_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    running && osc_rise && POWER_OK_IN && MASTER_CLEAR_N_IN && !WATCHDOG_TIMEOUT_IN
      && !BROWN_OUT_IN && !SLEEP_INSTR_IN |=> r_q.phase == $past(r_q.phase) + 2'd1)
    else $error("phase did not advance by one");

  pc_step_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    q4_end && !PC_LOAD_IN && !r_q.vec_pend && POWER_OK_IN && MASTER_CLEAR_N_IN
      && !WATCHDOG_TIMEOUT_IN && !BROWN_OUT_IN |=> PC_OUT == $past(PC_OUT) + 16'd1)
    else $error("pc did not step at first phase");

  branch_bubble_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    q4_end && PC_LOAD_IN |=> !EXECUTE_VALID_OUT)
    else $error("branch did not discard the fetched word");

  reset_q1_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    DEVICE_RESET_OUT |-> PHASE_OUT == 4'b0001 && !OPERAND_READ_OUT)
    else $error("phase not held at first phase in reset");

  power_low_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !POWER_OK_IN |=> DEVICE_RESET_OUT && r_q.flags == FLAGS_POR && PC_OUT == 16'h0000)
    else $error("low supply did not force power-on reset");

  power_up_timer_hold_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    r_q.state == ST_POWER_UP && r_q.power_up_timer_cnt != 17'd0 |-> DEVICE_RESET_OUT)
    else $error("released while power-up timer running");

  clear_flags_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    running && WATCHDOG_CLEAR_INSTR_IN && !SLEEP_INSTR_IN && !WATCHDOG_TIMEOUT_IN
      && POWER_OK_IN && MASTER_CLEAR_N_IN && !BROWN_OUT_IN |=> r_q.flags[3:2] == 2'b11)
    else $error("watchdog clear did not set flags");

  wdt_reset_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    running && WATCHDOG_TIMEOUT_IN && POWER_OK_IN && MASTER_CLEAR_N_IN
      && !BROWN_OUT_IN |=> r_q.flags == FLAGS_WDT && PC_OUT == 16'h0000)
    else $error("watchdog reset flags or pc wrong");

  wake_count_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    r_q.state == ST_WAKE |-> is_crystal(r_q.ctrl[1:0]))
    else $error("start-up count in a non-crystal mode");

endmodule
`default_nettype wire

// File: verilog/qprs_pkg.sv
// shared constants and types for the quad phase reset sequencer
package qprs_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] SEQ_ADDR    = 4'h8;
  localparam logic [3:0] KEEP_ADDR   = 4'hC;

  // control word fields
  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          CTRL_BOR_EN    = 2;
  localparam logic [2:0]  CTRL_RESET     = 3'h0;

  // status word fields: [5] fixed one, [4] global_int_disable,
  // [3] timeout_flag, [2] powerdown_flag, [1] brown_out_reset, [0] power-on
  localparam int          ST_GLINT_BIT   = 4;
  localparam logic [5:0]  FLAGS_POR      = 6'h3C; // 11 1100
  localparam logic [5:0]  FLAGS_BOR      = 6'h3D; // 11 1101
  localparam logic [5:0]  FLAGS_MASTER_CLEAR_N     = 6'h3F; // 11 1111
  localparam logic [5:0]  FLAGS_MASTER_CLEAR_N_SLP = 6'h3B; // 11 1011
  localparam logic [5:0]  FLAGS_WDT      = 6'h37; // 11 0111
  localparam logic [5:0]  FLAGS_WDT_WAKE = 6'h33; // 11 0011
  localparam logic [3:0]  LOW_INT_WAKE   = 4'hB;  // low bits on interrupt wake

  // oscillator modes
  localparam logic [1:0]  MODE_CRYSTAL   = 2'h0;
  localparam logic [1:0]  MODE_LF_XTAL   = 2'h1;
  localparam logic [1:0]  MODE_EXT_CLOCK = 2'h2;
  localparam logic [1:0]  MODE_RC        = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ        = 100;
  localparam int          POWER_UP_TIMER_MS        = 96;   // power-up timer, nominal
  localparam int          RC_TICK_NS     = 1000; // internal rc timer period
  localparam int          POWER_UP_TIMER_TICKS     = (POWER_UP_TIMER_MS * 1000000) / RC_TICK_NS;
  localparam logic [10:0] OST_PERIODS    = 11'h400; // 1024 oscillator periods
  localparam logic [15:0] RESET_VECTOR   = 16'h0000;
  localparam logic [15:0] INT_VECTOR     = 16'h0020; // arbitrary default
  localparam logic [1:0]  AXI_OKAY       = 2'h0;
  localparam logic [1:0]  AXI_DECERR     = 2'h3;

  typedef enum logic [2:0] {
    ST_POWER_DOWN, ST_WAIT_CLEAR, ST_POWER_UP, ST_RUN, ST_SLEEP, ST_HOLD, ST_WAKE
  } seq_state_type;

  typedef struct packed {
    seq_state_type state;
    logic [1:0]    phase;
    logic [15:0]   pc;
    logic [5:0]    flags;
    logic [10:0]   ost_cnt;
    logic [16:0]   power_up_timer_cnt;
    logic          osc_prev;
    logic          osc_ok;
    logic [2:0]    ctrl;
    logic          hold_from_sleep;
    logic          flush;
    logic          vec_pend;
    logic          vec_fire;
    logic          aw_full;
    logic          w_full;
    logic [3:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
  } seq_regs_type;

endpackage

// File: verif/osc_clear_source.sv
// oscillator, rc tick and master clear source facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module osc_clear_source (
  input  wire logic clk_in,
  input  wire logic clear_req_in,
  output logic      osc_out,
  output logic      level_ok_out,
  output logic      master_clear_n_out,
  output logic      rc_tick_out
);
  logic [6:0] cnt_q = 7'h00;
  // free running oscillator of four clocks, rc tick every 128 clocks
  // level valid late
  always @(posedge clk_in) begin
    cnt_q <= cnt_q + 7'h01;
    osc_out <= cnt_q[1];
    level_ok_out <= (level_ok_out === 1'b1) | (cnt_q == 7'h40);
    rc_tick_out <= (cnt_q == 7'h7F);
  end
  // pin held low while supply settles, bench decides when
  assign master_clear_n_out = ~clear_req_in;
endmodule
`default_nettype wire

// File: verif/quad_phase_reset_sequencer_bench.sv
// self-checking bench for the quad phase reset sequencer
`timescale 1ns/1ps
`default_nettype none
module quad_phase_reset_sequencer_bench;
  import qprs_pkg::*;
  logic        clk = 0, rst_n = 0, pwr = 0, bo = 0, clr = 1;
  logic [3:0]  ev = '0; // watchdog, clear instr, sleep, int wake
  logic        aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic [3:0]  aw_a = '0, ar_a = '0, ph;
  logic [31:0] w_d = '0, rd, r_d;
  logic [15:0] pc, p0;
  logic [1:0]  rsp, b_rsp, r_rsp;
  logic        osc, lvl, master_clear_n_n, tick, rst_o, aw_y, w_y, b_v, ar_y, r_v;
  logic        ale, oe_n, wr_n, pins_oe, qoe;
  logic        gd = 1, ld = 0, il, ex, opr, rwr, vf, qc;
  int          n_errors = 0, total_checks = 0, n;

  always #5 clk = ~clk;

  osc_clear_source src (.clk_in(clk), .clear_req_in(clr), .osc_out(osc),
    .level_ok_out(lvl), .master_clear_n_out(master_clear_n_n), .rc_tick_out(tick));

  // short power-up timer keeps the run brief
  quad_phase_reset_sequencer #(.POWER_UP_TIMER_COUNT(8)) dut (.CLK_IN(clk), .RESET_N_IN(rst_n),
    .OSC_INPUT_IN(osc), .OSC_LEVEL_OK_IN(lvl), .RC_TICK_IN(tick), .POWER_OK_IN(pwr),
    .BROWN_OUT_IN(bo), .MASTER_CLEAR_N_IN(master_clear_n_n), .WATCHDOG_TIMEOUT_IN(ev[3]),
    .WATCHDOG_CLEAR_INSTR_IN(ev[2]), .SLEEP_INSTR_IN(ev[1]), .INT_WAKE_IN(ev[0]),
    .GLOBAL_INT_DISABLE_IN(gd), .PC_LOAD_IN(ld), .PC_TARGET_IN(16'h0100),
    .EXT_EXEC_MODE_IN(1'b1), .PHASE_OUT(ph), .DEVICE_RESET_OUT(rst_o), .PC_OUT(pc),
    .INSTR_LATCH_OUT(il), .EXECUTE_VALID_OUT(ex), .OPERAND_READ_OUT(opr),
    .RESULT_WRITE_OUT(rwr), .VECTOR_FETCH_OUT(vf), .ALE_OUT(ale), .OE_N_OUT(oe_n),
    .WR_N_OUT(wr_n), .BUS_PINS_OE_OUT(pins_oe), .QUARTER_CLOCK_OUT(qc),
    .QUARTER_CLOCK_OE_OUT(qoe),
    .S_AXI_AWADDR_IN(aw_a), .S_AXI_AWVALID_IN(aw_v), .S_AXI_AWREADY_OUT(aw_y),
    .S_AXI_WDATA_IN(w_d), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(w_v),
    .S_AXI_WREADY_OUT(w_y), .S_AXI_BRESP_OUT(b_rsp), .S_AXI_BVALID_OUT(b_v),
    .S_AXI_BREADY_IN(b_r), .S_AXI_ARADDR_IN(ar_a), .S_AXI_ARVALID_IN(ar_v),
    .S_AXI_ARREADY_OUT(ar_y), .S_AXI_RDATA_OUT(r_d), .S_AXI_RRESP_OUT(r_rsp),
    .S_AXI_RVALID_OUT(r_v), .S_AXI_RREADY_IN(r_r));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // a wait that ran out of cycles ends the run
  task automatic hang(input int lim);
    if (n >= lim) begin
      n_errors++;
      test_done;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1;
    w_v <= 1;
    b_r <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (aw_y) aw_v <= 0;
      if (w_y) w_v <= 0;
    end while (b_v !== 1 && n < 200);
    hang(200);
    rsp = b_rsp;
    b_r <= 0;
  endtask
  task automatic rdw(input logic [3:0] a);
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1;
    r_r <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (ar_y) ar_v <= 0;
    end while (r_v !== 1 && n < 200);
    hang(200);
    rd = r_d;
    rsp = r_rsp;
    r_r <= 0;
  endtask
  task automatic st(input logic [5:0] exp);
    rdw(STATUS_ADDR);
    chk(rd[5:0], exp);
  endtask
  task automatic wait_run(input int lim);
    for (n = 0; rst_o !== 0 && n < lim; n++) @(posedge clk);
    hang(lim);
  endtask
  task automatic wait_ph(input logic [3:0] p, input int lim);
    for (n = 0; ph !== p && n < lim; n++) @(posedge clk);
    hang(lim);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= '0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    pwr <= 1;
    repeat (20) @(posedge clk);
    chk({ph, ale, oe_n, wr_n, pins_oe, rst_o}, 9'b0001_0_1111);
    clr <= 0;
    rdw(CTRL_ADDR);
    chk(rd, 32'h0000_0000);
    st(FLAGS_POR);
    // start-up count of 1024 oscillator periods outlasts the timer
    repeat (2000) @(posedge clk);
    chk(rst_o, 1);
    wait_run(4000);
    // one phase per oscillator rise, pc steps once per cycle
    wait_ph(4'h1, 50);
    p0 = pc;
    wait_ph(4'h2, 6);
    chk({il, opr, rwr, qc}, 4'b0100);
    wait_ph(4'h4, 6);
    chk({il, opr, rwr, qc}, 4'b0001);
    wait_ph(4'h8, 6);
    chk({il, opr, rwr, qc}, 4'b1011);
    wait_ph(4'h1, 6);
    chk(pc, p0 + 16'h0001);
    // a pc load in the fourth phase discards the next cycle
    wait_ph(4'h8, 16);
    ld <= 1;
    wait_ph(4'h1, 8);
    ld <= 0;
    chk({ex, pc}, {1'b0, 16'h0100});
    wait_ph(4'h8, 16);
    wait_ph(4'h1, 8);
    chk({ex, pc}, {1'b1, 16'h0101});
    // master clear in run: scratch kept, no time-out on release
    wr(KEEP_ADDR, 32'h5A5A_0F0F);
    clr <= 1;
    repeat (10) @(posedge clk);
    chk({rst_o, pc}, {1'b1, RESET_VECTOR});
    clr <= 0;
    wait_run(20);
    st(FLAGS_MASTER_CLEAR_N);
    rdw(KEEP_ADDR);
    chk(rd, 32'h5A5A_0F0F);
    wr(SEQ_ADDR, 32'h0000_0000);
    chk(rsp, AXI_DECERR);
    rdw(SEQ_ADDR);
    chk(rd[23:21], 3'h3);
    // watchdog reset, then the clear instruction
    pulse(4'h8);
    wait_run(20);
    st(FLAGS_WDT);
    pulse(4'h4);
    st(6'h3F);
    // sleep and watchdog wake in crystal mode waits the start-up count
    pulse(4'h2);
    pulse(4'h8);
    repeat (2000) @(posedge clk);
    chk(rst_o, 1);
    wait_run(4000);
    st(FLAGS_WDT_WAKE);
    // rc mode: quarter clock driven, wakes without a start-up count
    wr(CTRL_ADDR, {30'h0, MODE_RC});
    chk(qoe, 1);
    pulse(4'h2);
    pulse(4'h1);
    wait_run(50);
    st({2'b11, LOW_INT_WAKE});
    // interrupts enabled: next instruction first, then the vector
    gd <= 0;
    pulse(4'h2);
    pulse(4'h1);
    wait_run(50);
    st({2'b10, LOW_INT_WAKE});
    for (n = 0; vf !== 1 && n < 40; n++) @(posedge clk);
    hang(40);
    chk(pc, INT_VECTOR);
    pulse(4'h2);
    clr <= 1;
    repeat (5) @(posedge clk);
    clr <= 0;
    wait_run(50);
    st(FLAGS_MASTER_CLEAR_N_SLP);
    // brown-out with detection enabled
    wr(CTRL_ADDR, 32'h0000_0004);
    bo <= 1;
    repeat (5) @(posedge clk);
    chk(rst_o, 1);
    bo <= 0;
    wait_run(20);
    st(FLAGS_BOR);
    // supply drop gives a full power-on sequence
    pwr <= 0;
    repeat (5) @(posedge clk);
    chk({rst_o, pc}, {1'b1, RESET_VECTOR});
    pwr <= 1;
    wait_run(6000);
    st(FLAGS_POR);
    test_done;
  end
endmodule
`default_nettype wire
